// ### dv/ais_core_model.sv
/* processor core model: register strobes and conversion starts.
   assumes it shares clk_sys with the block. */
`timescale 1ns/1ps
module ais_core_model (
    input logic clk_sys,
    input logic [7:0] sfr_rdata,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic conv_start
);
    initial {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, conv_start} = 19'h0;
    // released lines are inverted, never left holding stale values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        sfr_addr <= ~a;
        sfr_wdata <= ~d;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        sfr_addr <= ~a;
        #1;
        d = sfr_rdata;
    endtask
    // settling wait after a reselect, then one start pulse
    task automatic start;
        repeat (4) @(posedge clk_sys);
        conv_start <= 1'b1;
        @(posedge clk_sys);
        conv_start <= 1'b0;
    endtask
endmodule

// ### dv/ais_input_select_asserts.sv
/* checker for the converter input-selection block.
   assumes a bind onto ais_input_select; it sees the ports only. */
`timescale 1ns/1ps
`include "ais_defs.svh"
module ais_input_select_asserts (
    input logic clk_sys,
    input logic nrst,
    input logic sfr_wr,
    input logic sfr_rd,
    input logic low_power_tracking_enable,
    input logic conv_start,
    input logic sar_tick,
    input logic pos_temp_sel,
    input logic pos_vdd_sel,
    input logic neg_vref_sel,
    input logic neg_gnd_sel,
    input logic single_ended,
    input logic tracking,
    input logic converting,
    input logic conv_done,
    input logic [7:0] sfr_addr,
    input logic [7:0] sfr_wdata,
    input logic [7:0] sfr_rdata,
    input logic [15:0] pos_pin_sel,
    input logic [15:0] neg_pin_sel
);
    // one domain, so clock and reset are given once
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // steps: a code write, a start taken from idle
    sequence s_wr(a, c);
        sfr_wr && sfr_addr == a && sfr_wdata[4:0] == c;
    endsequence
    sequence s_lp_go;
        conv_start && low_power_tracking_enable && !tracking && !converting;
    endsequence
    sequence s_norm_go;
        conv_start && !low_power_tracking_enable && tracking && !converting;
    endsequence
    // pin codes land one-hot at the written index
    property p_pos_pin;
        logic [3:0] v;
        (sfr_wr && sfr_addr == `AIS_POS_ADDR && !sfr_wdata[4], v = sfr_wdata[3:0])
            |=> pos_pin_sel == (16'h1 << v) && !pos_temp_sel;
    endproperty
    AST_POS_PIN: assert property (p_pos_pin)
        else $error("pin select wrong");
    AST_POS_TEMP: assert property (s_wr(`AIS_POS_ADDR, `AIS_POS_TEMP)
        |=> pos_temp_sel && pos_pin_sel == 16'h0) else $error("temp select wrong");
    AST_POS_VDD: assert property (s_wr(`AIS_POS_ADDR, `AIS_POS_VDD)
        |=> pos_vdd_sel && !pos_temp_sel) else $error("supply select wrong");
    AST_NEG_GND: assert property (s_wr(`AIS_NEG_ADDR, `AIS_NEG_GND)
        |=> neg_gnd_sel && !neg_vref_sel && neg_pin_sel == 16'h0) else $error("ground wrong");
    AST_SE_GND: assert property (single_ended == neg_gnd_sel)
        else $error("mode wrong");
    // mode follows the written code itself, not the decoded switch
    AST_SE_WR: assert property (sfr_wr && sfr_addr == `AIS_NEG_ADDR
        |=> single_ended == ($past(sfr_wdata[4:0]) == `AIS_NEG_GND))
        else $error("mode after write wrong");
    AST_RD_GND: assert property (sfr_rd && sfr_addr == `AIS_NEG_ADDR && neg_gnd_sel
        |=> sfr_rdata == {`AIS_UNUSED_BITS, `AIS_NEG_GND}) else $error("readback wrong");
    AST_LP_TRACK: assert property (s_lp_go |=> tracking [*3])
        else $error("tracking too short");
    AST_DONE: assert property (s_norm_go ##1 sar_tick [*5] ##1 sar_tick [*5]
        |=> conv_done) else $error("conversion length wrong");
endmodule
bind ais_input_select ais_input_select_asserts u_chk (.clk_sys, .nrst, .sfr_wr, .sfr_rd,
    .low_power_tracking_enable, .conv_start, .sar_tick, .pos_temp_sel, .pos_vdd_sel,
    .neg_vref_sel, .neg_gnd_sel, .single_ended, .tracking, .converting, .conv_done,
    .sfr_addr, .sfr_wdata, .sfr_rdata, .pos_pin_sel, .neg_pin_sel);

// ### dv/ais_input_select_tb.sv
/* bench: register rows, mid-run reset, four conversions.
   assumes the core model owns the register bus and the start pulse. */
`timescale 1ns/1ps
`include "ais_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module ais_input_select_tb;
    typedef struct packed {logic [7:0] a, d; logic [17:0] p, n; logic s; logic [7:0] r;} ais_row_type;
    logic clk_sys = 1'b0, nrst = 1'b0, low_power_tracking_enable = 1'b0, sar_tick = 1'b1;
    logic sfr_wr, sfr_rd, conv_start, pos_temp_sel, pos_vdd_sel, neg_vref_sel, neg_gnd_sel;
    logic single_ended, tracking, converting, conv_done;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_val;
    logic [15:0] pos_pin_sel, neg_pin_sel;
    logic [36:0] sel;
    int failures = 0, checked = 0, n;
    // rows: address, data, positive and negative selects, mode, readback
    ais_row_type rows [9] = '{'{8'hbb,8'he0,18'h1,18'h0,1'b0,8'h00},
        '{8'hbb,8'h10,18'h10000,18'h0,1'b0,8'h10}, '{8'hbb,8'h11,18'h20000,18'h0,1'b0,8'h11},
        '{8'hbb,8'hf2,18'h0,18'h0,1'b0,8'h12}, '{8'hba,8'haf,18'h0,18'h8000,1'b0,8'h0f},
        '{8'hba,8'h10,18'h0,18'h10000,1'b0,8'h10}, '{8'hba,8'h11,18'h0,18'h20000,1'b1,8'h11},
        '{8'hbc,8'h00,18'h0,18'h20000,1'b1,8'h00}, '{8'hba,8'h1f,18'h0,18'h0,1'b0,8'h1f}};
    ais_input_select DUT (.clk_sys, .nrst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .low_power_tracking_enable, .conv_start, .sar_tick, .pos_pin_sel, .pos_temp_sel,
        .pos_vdd_sel, .neg_pin_sel, .neg_vref_sel, .neg_gnd_sel, .single_ended, .tracking,
        .converting, .conv_done);
    ais_core_model core (.clk_sys, .sfr_rdata, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
        .conv_start);
    assign sel = {pos_vdd_sel, pos_temp_sel, pos_pin_sel, neg_gnd_sel, neg_vref_sel,
        neg_pin_sel, single_ended};
    always #20 clk_sys = ~clk_sys;
    task automatic wrap_up;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // k stalls the tick for k cycles; a busy start lands mid-run
    task automatic conv(input logic lp, input int k);
        @(posedge clk_sys);
        low_power_tracking_enable <= lp;
        core.start();
        sar_tick <= (k == 0);
        n = 0;
        #1;
        `CHK("tracking", lp, tracking)
        `CHK("converting", !lp, converting)
        while (conv_done !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            n++;
            sar_tick <= (n >= k);
            core.conv_start <= (n == 5);
            #1;
        end
        `CHK("conversion cycles", 10 + 3 * lp + k, n)
        `CHK("idle after done", 1'b0, converting)
        `CHK("tracking after done", !lp, tracking)
        $display("conversion lp %0d stall %0d done", lp, k);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            core.wr(rows[i].a, rows[i].d);
            #1;
            `CHK("positive", rows[i].p, sel[36:19])
            `CHK("negative", rows[i].n, sel[18:1])
            `CHK("single ended", rows[i].s, sel[0])
            core.rd(rows[i].a, rd_val);
            `CHK("readback", rows[i].r, rd_val)
        end
        $display("register rows done");
        core.wr(8'hbb, 8'h03);
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        `CHK("selects after reset", 37'h0, sel)
        core.rd(8'hba, rd_val);
        `CHK("negative reset", {`AIS_UNUSED_BITS, `AIS_SEL_RESET}, rd_val)
        core.rd(8'hbb, rd_val);
        `CHK("positive reset", {`AIS_UNUSED_BITS, `AIS_SEL_RESET}, rd_val)
        $display("reset test done");
        for (int m = 0; m < 4; m++) conv(m[0], m[1] ? 4 : 0);
        wrap_up();
    end
    // the whole run needs about one hundred thirty cycles
    initial begin
        #(40 * 1000);
        failures++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule

// ### hdl/ais_defs.svh
/*
 * constants for the converter input-selection block: register offsets,
 * field layout, reset values, selector codes and conversion timing.
 * assumes it is included by bare name from the design file.
 */
// ==========================================================
// Contract
// - positive codes: pins, temp sensor, supply, none
// - negative codes: pins, reference, ground, none
// - ground negative means single-ended unsigned
// - low-power mode tracks three conversion clocks
// - results carry ten bits of resolution
`ifndef AIS_DEFS_SVH
`define AIS_DEFS_SVH

// ==========================================================
// register map on the special function register bus
`define AIS_NEG_ADDR 8'hba
`define AIS_POS_ADDR 8'hbb
`define AIS_SEL_RESET 5'h1f
`define AIS_CODE_LSB 0
`define AIS_CODE_MSB 4
`define AIS_UNUSED_BITS 3'h0

// ==========================================================
// selector codes
`define AIS_POS_TEMP 5'h10
`define AIS_POS_VDD 5'h11
`define AIS_NEG_VREF 5'h10
`define AIS_NEG_GND 5'h11
`define AIS_NONE_FIRST 5'h12
`define AIS_PIN_LAST 5'h0f

// ==========================================================
// conversion timing, in conversion-clock ticks
`define AIS_TRACK_TICKS 4'h3
`define AIS_RESULT_BITS 4'ha

`endif

// ### hdl/ais_input_select.sv
/*
 * input selection for the on-chip ten-bit converter: two selector
 * registers on the special function register bus, their decode onto
 * the multiplexer switches, the single-ended/differential decision,
 * and the track/convert sequencing that follows a conversion start.
 * assumes the bus, the start pulse, the conversion-clock tick and the
 * tracking-mode bit all come from logic on clk_sys.
 */
`timescale 1ns/1ps
`include "ais_defs.svh"

module ais_input_select (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic low_power_tracking_enable,
    input wire logic conv_start,
    input wire logic sar_tick,
    output logic [15:0] pos_pin_sel,
    output logic pos_temp_sel,
    output logic pos_vdd_sel,
    output logic [15:0] neg_pin_sel,
    output logic neg_vref_sel,
    output logic neg_gnd_sel,
    output logic single_ended,
    output logic tracking,
    output logic converting,
    output logic conv_done
);

    // ==========================================================
    // decode helpers

    // one-hot port pin switch for a code, zero above the pin range
    function automatic logic [15:0] pin_decode(input logic [4:0] code);
        logic [15:0] hot;
        hot = 16'h0000;
        if (code <= `AIS_PIN_LAST) begin
            hot[code[3:0]] = 1'b1;
        end
        return hot;
    endfunction

    // ==========================================================
    // selector registers

    ais_pkg::ais_code_type pos_code_reg; // positive_select_code
    ais_pkg::ais_code_type pos_code_next;
    ais_pkg::ais_code_type neg_code_reg; // negative_select_code
    ais_pkg::ais_code_type neg_code_next;
    logic [7:0] rdata_reg; // registered read answer
    logic [7:0] rdata_next;

    // bus writes and reads, both taken in one cycle if both strobes are high; a read then returns the old code
    always_comb begin
        pos_code_next = pos_code_reg;
        neg_code_next = neg_code_reg;
        rdata_next = 8'h00;
        if (sfr_wr) begin
            // only the low five bits land; the top three are dropped
            if (sfr_addr == `AIS_POS_ADDR) begin
                pos_code_next = sfr_wdata[`AIS_CODE_MSB:`AIS_CODE_LSB];
            end else if (sfr_addr == `AIS_NEG_ADDR) begin
                neg_code_next = sfr_wdata[`AIS_CODE_MSB:`AIS_CODE_LSB];
            end
        end
        if (sfr_rd) begin
            // unmapped addresses answer zero so an or-tree stays clean
            if (sfr_addr == `AIS_POS_ADDR) begin
                rdata_next = {`AIS_UNUSED_BITS, pos_code_reg};
            end else if (sfr_addr == `AIS_NEG_ADDR) begin
                rdata_next = {`AIS_UNUSED_BITS, neg_code_reg};
            end
        end
    end

    // register stage for the selector group
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pos_code_reg <= `AIS_SEL_RESET;
            neg_code_reg <= `AIS_SEL_RESET;
            rdata_reg <= 8'h00;
        end else begin
            pos_code_reg <= pos_code_next;
            neg_code_reg <= neg_code_next;
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================================
    // multiplexer switch decode

    logic [15:0] pos_pin_reg;
    logic [15:0] pos_pin_next;
    logic pos_temp_reg;
    logic pos_temp_next;
    logic pos_vdd_reg;
    logic pos_vdd_next;
    logic [15:0] neg_pin_reg;
    logic [15:0] neg_pin_next;
    logic neg_vref_reg;
    logic neg_vref_next;
    logic neg_gnd_reg;
    logic neg_gnd_next;
    logic single_reg; // unsigned single-ended results
    logic single_next;

    // decode from the next code so switches follow a write in one cycle;
    // codes from the none range leave every switch open
    always_comb begin
        pos_pin_next = pin_decode(pos_code_next);
        pos_temp_next = (pos_code_next == `AIS_POS_TEMP);
        pos_vdd_next = (pos_code_next == `AIS_POS_VDD);
        neg_pin_next = pin_decode(neg_code_next);
        neg_vref_next = (neg_code_next == `AIS_NEG_VREF);
        neg_gnd_next = (neg_code_next == `AIS_NEG_GND);
        // any negative other than ground, even none, is differential
        single_next = (neg_code_next == `AIS_NEG_GND);
    end

    // register stage for the switch group; reset matches code 11111
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pos_pin_reg <= 16'h0000;
            pos_temp_reg <= 1'b0;
            pos_vdd_reg <= 1'b0;
            neg_pin_reg <= 16'h0000;
            neg_vref_reg <= 1'b0;
            neg_gnd_reg <= 1'b0;
            single_reg <= 1'b0;
        end else begin
            pos_pin_reg <= pos_pin_next;
            pos_temp_reg <= pos_temp_next;
            pos_vdd_reg <= pos_vdd_next;
            neg_pin_reg <= neg_pin_next;
            neg_vref_reg <= neg_vref_next;
            neg_gnd_reg <= neg_gnd_next;
            single_reg <= single_next;
        end
    end

    // ==========================================================
    // track and convert sequencing

    ais_pkg::ais_state_type state_reg;
    ais_pkg::ais_state_type state_next;
    logic [3:0] tick_cnt_reg; // conversion-clock ticks in this state
    logic [3:0] tick_cnt_next;
    logic track_reg;
    logic track_next;
    logic conv_reg;
    logic conv_next;
    logic done_reg;
    logic done_next;

    // sequencer; a start while busy is ignored, since the sampled input
    // would be disturbed. settling after a reselect is left to software,
    // which low-power mode eases by always tracking first
    always_comb begin
        state_next = state_reg;
        tick_cnt_next = tick_cnt_reg;
        done_next = 1'b0;
        case (state_reg)
            ais_pkg::AIS_IDLE: begin
                tick_cnt_next = 4'h0;
                if (conv_start && low_power_tracking_enable) begin
                    state_next = ais_pkg::AIS_TRACK;
                end else if (conv_start) begin
                    // normal mode has been tracking all along
                    state_next = ais_pkg::AIS_CONV;
                end
            end
            ais_pkg::AIS_TRACK: begin
                if (sar_tick) begin
                    if (tick_cnt_reg == `AIS_TRACK_TICKS - 4'h1) begin
                        tick_cnt_next = 4'h0;
                        state_next = ais_pkg::AIS_CONV;
                    end else begin
                        tick_cnt_next = tick_cnt_reg + 4'h1;
                    end
                end
            end
            ais_pkg::AIS_CONV: begin
                // one conversion-clock tick per result bit
                if (sar_tick) begin
                    if (tick_cnt_reg == `AIS_RESULT_BITS - 4'h1) begin
                        tick_cnt_next = 4'h0;
                        state_next = ais_pkg::AIS_IDLE;
                        done_next = 1'b1;
                    end else begin
                        tick_cnt_next = tick_cnt_reg + 4'h1;
                    end
                end
            end
            default: begin
                // illegal code recovers to idle
                state_next = ais_pkg::AIS_IDLE;
                tick_cnt_next = 4'h0;
            end
        endcase
        // normal mode tracks whenever not converting
        track_next = (state_next == ais_pkg::AIS_TRACK) ||
                     ((state_next == ais_pkg::AIS_IDLE) && !low_power_tracking_enable);
        conv_next = (state_next == ais_pkg::AIS_CONV);
    end

    // register stage for the sequencer group
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_reg <= ais_pkg::AIS_IDLE;
            tick_cnt_reg <= 4'h0;
            track_reg <= 1'b0;
            conv_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tick_cnt_reg <= tick_cnt_next;
            track_reg <= track_next;
            conv_reg <= conv_next;
            done_reg <= done_next;
        end
    end

    // ==========================================================
    // outputs, all straight from flip-flops
    assign sfr_rdata = rdata_reg;
    assign pos_pin_sel = pos_pin_reg;
    assign pos_temp_sel = pos_temp_reg;
    assign pos_vdd_sel = pos_vdd_reg;
    assign neg_pin_sel = neg_pin_reg;
    assign neg_vref_sel = neg_vref_reg;
    assign neg_gnd_sel = neg_gnd_reg;
    assign single_ended = single_reg;
    assign tracking = track_reg;
    assign converting = conv_reg;
    assign conv_done = done_reg;

endmodule

// ### hdl/ais_pkg.sv
/*
 * types for the converter input-selection block.
 * assumes the constants header is compiled alongside it.
 */
package ais_pkg;

    // ==========================================================
    // conversion sequencer states, one-hot
    typedef enum logic [2:0] {
        AIS_IDLE  = 3'h1,
        AIS_TRACK = 3'h2,
        AIS_CONV  = 3'h4
    } ais_state_type;

    // selector code as held in a register
    typedef logic [4:0] ais_code_type;

endpackage
